/* verilog/rtcc_calendar.v */
/*
  Calendar counting chain of a real-time clock with an APB register slave.
  Sub-second, seconds, minutes, hours, weekday, date and month counters, plus a control register.
  Assumes pclk at 100 MHz, zero-wait APB master, and a year counter outside that supplies year_bcd.
*/
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "rtcc_regs.vh"

module rtcc_calendar #(
  parameter [`RTCC_DIV_W-1:0] TICK_CYCLES = `RTCC_TICK_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Year counter outside
  input wire [7:0] year_bcd,
  output reg year_carry_r
);

  // Counters hold no reset so that their contents survive presetn.
  reg [6:0] subsec_r;
  reg [7:0] sec_r;
  reg [7:0] min_r;
  reg [7:0] hour_r;
  reg [7:0] week_r;
  reg [7:0] date_r;
  reg [7:0] month_r;
  reg start_r;
  reg carry_flag_r;

  reg [6:0] subsec_nxt;
  reg [7:0] sec_nxt;
  reg [7:0] min_nxt;
  reg [7:0] hour_nxt;
  reg [7:0] week_nxt;
  reg [7:0] date_nxt;
  reg [7:0] month_nxt;
  reg sec_in;
  reg min_in;
  reg hour_in;
  reg day_in;
  reg month_in;
  reg year_in;
  reg [8:0] sec_step;
  reg [8:0] min_step;
  reg [8:0] hour_step;
  reg [8:0] week_step;
  reg [8:0] date_step;
  reg [8:0] month_step;

  wire tick;
  wire [7:0] last_date;
  wire setup;
  wire wr;
  wire mapped;
  wire [2:0] idx;
  wire ctl_wr;
  wire clr_sub;
  wire thirty_second_adjust_bit;
  wire run_tick;
  wire rd_setup;
  wire sub_wrap;
  wire wr_sec;
  wire wr_min;
  wire wr_hour;
  wire wr_week;
  wire wr_date;
  wire wr_month;

  // Advances a BCD value; at the last value it returns first with the carry in bit 8.
  function [8:0] bcd_step;
    input [7:0] v;
    input [7:0] last;
    input [7:0] first;
    begin
      if (v == last)
        bcd_step = {1'b1, first};
      else if (v[3:0] == 4'h9)
        bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
        bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Read view of the counters, unused high bits forced to zero.
  function [31:0] read_mux;
    input [2:0] i;
    begin
      case (i)
        `RTCC_IDX_SUBSEC: read_mux = {25'h0000000, subsec_r};
        `RTCC_IDX_SEC: read_mux = {25'h0000000, sec_r[6:0]};
        `RTCC_IDX_MIN: read_mux = {25'h0000000, min_r[6:0]};
        `RTCC_IDX_HOUR: read_mux = {26'h0000000, hour_r[5:0]};
        `RTCC_IDX_WEEK: read_mux = {29'h00000000, week_r[2:0]};
        `RTCC_IDX_DATE: read_mux = {26'h0000000, date_r[5:0]};
        `RTCC_IDX_MONTH: read_mux = {27'h0000000, month_r[4:0]};
        `RTCC_IDX_CTRL: read_mux = {28'h0000000, carry_flag_r, 2'b00, start_r};
        default: read_mux = 32'h00000000;
      endcase
    end
  endfunction

  // Write view of a counter: bits outside its field are stored as zero.
  function [7:0] wr_field;
    input [2:0] i;
    input [7:0] d;
    begin
      case (i)
        `RTCC_IDX_SEC: wr_field = {1'b0, d[6:0]};
        `RTCC_IDX_MIN: wr_field = {1'b0, d[6:0]};
        `RTCC_IDX_HOUR: wr_field = {2'b00, d[5:0]};
        `RTCC_IDX_WEEK: wr_field = {5'h00, d[2:0]};
        `RTCC_IDX_DATE: wr_field = {2'b00, d[5:0]};
        `RTCC_IDX_MONTH: wr_field = {3'h0, d[4:0]};
        default: wr_field = 8'h00;
      endcase
    end
  endfunction

  assign idx = paddr[4:2];
  assign mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign ctl_wr = wr && (idx == `RTCC_IDX_CTRL);
  assign clr_sub = ctl_wr && (pwdata[`RTCC_CTL_DIVRST] || pwdata[`RTCC_CTL_ADJ]);
  assign thirty_second_adjust_bit = ctl_wr && pwdata[`RTCC_CTL_ADJ];
  assign run_tick = tick && start_r;
  assign rd_setup = setup && !pwrite && mapped;
  assign sub_wrap = (subsec_r == `RTCC_SUBSEC_LAST);
  // Write strobes per counter; an errored transfer never reaches them.
  assign wr_sec = wr && (idx == `RTCC_IDX_SEC);
  assign wr_min = wr && (idx == `RTCC_IDX_MIN);
  assign wr_hour = wr && (idx == `RTCC_IDX_HOUR);
  assign wr_week = wr && (idx == `RTCC_IDX_WEEK);
  assign wr_date = wr && (idx == `RTCC_IDX_DATE);
  assign wr_month = wr && (idx == `RTCC_IDX_MONTH);

  rtcc_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clr(clr_sub),
    .tick_r(tick)
  );

  rtcc_month_len u_len (
    .month(month_r),
    .year(year_bcd),
    .last_date(last_date)
  );

  // Next value and carry of every stage from seconds to month, whether or not that stage steps.
  always @* begin
    sec_step = bcd_step(sec_r, `RTCC_SEC_LAST, `RTCC_ZERO);
    min_step = bcd_step(min_r, `RTCC_MIN_LAST, `RTCC_ZERO);
    hour_step = bcd_step(hour_r, `RTCC_HOUR_LAST, `RTCC_ZERO);
    week_step = bcd_step(week_r, `RTCC_WEEK_LAST, `RTCC_ZERO);
    date_step = bcd_step(date_r, last_date, `RTCC_ONE);
    month_step = bcd_step(month_r, `RTCC_MONTH_LAST, `RTCC_ONE);
  end

  // Carry chain; a stage steps only when every stage below it wraps, except that an adjust steps the minute from 30 seconds on, carrying upward.
  always @* begin
    sec_in = run_tick && sub_wrap && !thirty_second_adjust_bit;
    if (thirty_second_adjust_bit)
      min_in = (sec_r >= `RTCC_ADJ_HALF);
    else
      min_in = sec_in && sec_step[8];
    hour_in = min_in && min_step[8];
    day_in = hour_in && hour_step[8];
    month_in = day_in && date_step[8];
    year_in = month_in && month_step[8];
  end

  // Next counter values; a register write in the same cycle wins over counting.
  always @* begin
    if (clr_sub)
      subsec_nxt = 7'h00;
    else if (run_tick)
      subsec_nxt = subsec_r + 7'h01;
    else
      subsec_nxt = subsec_r;
    // Adjust rounds to the nearest minute: seconds clear, and the minute steps from 30 on.
    if (wr_sec)
      sec_nxt = wr_field(`RTCC_IDX_SEC, pwdata[7:0]);
    else if (thirty_second_adjust_bit)
      sec_nxt = `RTCC_ZERO;
    else if (sec_in)
      sec_nxt = sec_step[7:0];
    else
      sec_nxt = sec_r;
    if (wr_min)
      min_nxt = wr_field(`RTCC_IDX_MIN, pwdata[7:0]);
    else if (min_in)
      min_nxt = min_step[7:0];
    else
      min_nxt = min_r;
    if (wr_hour)
      hour_nxt = wr_field(`RTCC_IDX_HOUR, pwdata[7:0]);
    else if (hour_in)
      hour_nxt = hour_step[7:0];
    else
      hour_nxt = hour_r;
    if (wr_week)
      week_nxt = wr_field(`RTCC_IDX_WEEK, pwdata[7:0]);
    else if (day_in)
      week_nxt = week_step[7:0];
    else
      week_nxt = week_r;
    if (wr_date)
      date_nxt = wr_field(`RTCC_IDX_DATE, pwdata[7:0]);
    else if (day_in)
      date_nxt = date_step[7:0];
    else
      date_nxt = date_r;
    if (wr_month)
      month_nxt = wr_field(`RTCC_IDX_MONTH, pwdata[7:0]);
    else if (month_in)
      month_nxt = month_step[7:0];
    else
      month_nxt = month_r;
  end

  // No reset on the sub-second stage: presetn leaves it alone; only a DIVRST or ADJ control write clears it.
  always @(posedge pclk) begin
    subsec_r <= subsec_nxt;
  end

  // The calendar registers have no reset either.
  always @(posedge pclk) begin
    sec_r <= sec_nxt;
    min_r <= min_nxt;
    hour_r <= hour_nxt;
    week_r <= week_nxt;
    date_r <= date_nxt;
    month_r <= month_nxt;
  end

  // Control bits and the year carry pulse.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= `RTCC_CTL_START_RST;
      carry_flag_r <= 1'b0;
      year_carry_r <= 1'b0;
    end else begin
      if (ctl_wr)
        start_r <= pwdata[`RTCC_CTL_START];
      // A carry in the clearing cycle still sets the flag.
      if (sec_in || min_in)
        carry_flag_r <= 1'b1;
      else if (ctl_wr && !pwdata[`RTCC_CTL_CARRY])
        carry_flag_r <= 1'b0;
      year_carry_r <= year_in;
    end
  end

  // Bus answer: pready and pslverr stand for the one access cycle; read data holds until the next setup cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (rd_setup)
        prdata <= read_mux(idx);
      else if (setup)
        prdata <= 32'h00000000;
    end
  end

endmodule

/* verilog/rtcc_regs.vh */
/*
  Register indices, field positions, reset values, counter limits and timing counts of the RTC calendar chain.
  Assumes an APB slave with 32-bit data, where register index n sits at byte address 4*n.
*/
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH

// Register indices; byte address is four times the index.
`define RTCC_IDX_SUBSEC 3'h0
`define RTCC_IDX_SEC 3'h1
`define RTCC_IDX_MIN 3'h2
`define RTCC_IDX_HOUR 3'h3
`define RTCC_IDX_WEEK 3'h4
`define RTCC_IDX_DATE 3'h5
`define RTCC_IDX_MONTH 3'h6
`define RTCC_IDX_CTRL 3'h7

// Fields of the control register.
`define RTCC_CTL_START 0
`define RTCC_CTL_DIVRST 1
`define RTCC_CTL_ADJ 2
`define RTCC_CTL_CARRY 3
`define RTCC_CTL_START_RST 1'b1

// Counter limits in BCD; the sub-second limit is binary.
`define RTCC_SEC_LAST 8'h59
`define RTCC_MIN_LAST 8'h59
`define RTCC_HOUR_LAST 8'h23
`define RTCC_WEEK_LAST 8'h06
`define RTCC_MONTH_LAST 8'h12
`define RTCC_ZERO 8'h00
`define RTCC_ONE 8'h01
`define RTCC_ADJ_HALF 8'h30
`define RTCC_SUBSEC_LAST 7'h7f

// Time base: the sub-second chain is stepped at 128 Hz so that bit 0 shows 64 Hz.
// One step lasts 7812500 ns, which is this many 10 ns clock periods.
`define RTCC_TICK_CYCLES 20'hbebc2
`define RTCC_DIV_W 20

`endif

/* verilog/rtcc_tick_div.v */
/*
  Divider that turns pclk into the 128 Hz stepping pulse of the calendar chain.
  Assumes one clock; the clear input restarts the divider phase.
*/
`timescale 1ns/100ps
`include "rtcc_regs.vh"

module rtcc_tick_div #(
  parameter [`RTCC_DIV_W-1:0] TICK_CYCLES = `RTCC_TICK_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire clr,
  // Stepping pulse, one cycle wide
  output reg tick_r
);

  reg [`RTCC_DIV_W-1:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {`RTCC_DIV_W{1'b0}};
      tick_r <= 1'b0;
    end else if (clr) begin
      cnt_r <= {`RTCC_DIV_W{1'b0}};
      tick_r <= 1'b0;
    end else if (cnt_r == TICK_CYCLES - 1'b1) begin
      cnt_r <= {`RTCC_DIV_W{1'b0}};
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

endmodule

/* verilog/rtcc_month_len.v */
/*
  Last valid BCD date of a month, with leap-year correction from the two-digit BCD year.
  Assumes month and year hold BCD values; month 00 is treated as a 31-day month.
*/
`timescale 1ns/100ps
`include "rtcc_regs.vh"

module rtcc_month_len (
  // Calendar inputs
  input wire [7:0] month,
  input wire [7:0] year,
  // Last date of the month
  output reg [7:0] last_date
);

  reg leap;

  always @* begin
    // A BCD year is a multiple of 4 when even tens pair with 0/4/8, or odd tens with 2/6; 00 counts.
    if (year[4] == 1'b0)
      leap = (year[3:0] == 4'h0) || (year[3:0] == 4'h4) || (year[3:0] == 4'h8);
    else
      leap = (year[3:0] == 4'h2) || (year[3:0] == 4'h6);
    case (month)
      8'h02: last_date = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  end

endmodule

/* bench/rtcc_calendar_props.sv */
/*
  Port checker of the calendar chain and its APB slave.
  Assumes it is bound to rtcc_calendar and sees its ports only.
*/
`timescale 1ns/100ps
module rtcc_calendar_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Year counter
  input wire [7:0] year_bcd,
  input wire year_carry_r
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && psel && penable && !pwrite;
  wire bad = paddr[11:5] != 0 || paddr[1:0] != 0;
  chk_ready_one_wait: assert property (psel && !penable |=> pready && penable) else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  chk_err_unmapped: assert property (psel && !penable && bad |=> pslverr) else $error("no pslverr");
  chk_err_with_ready: assert property (pslverr |-> pready && bad) else $error("stray pslverr");
  chk_subsec_top_zero: assert property (rd && paddr == 12'h000 |-> prdata[31:7] == 0) else $error("subsec");
  chk_sec_bcd_range: assert property (rd && paddr == 12'h004 |-> prdata <= 32'h59) else $error("sec");
  chk_min_bcd_range: assert property (rd && paddr == 12'h008 |-> prdata <= 32'h59) else $error("min");
  chk_hour_bcd_range: assert property (rd && paddr == 12'h00c |-> prdata <= 32'h23) else $error("hour");
  chk_week_range: assert property (rd && paddr == 12'h010 |-> prdata <= 32'h6) else $error("week");
  chk_date_range: assert property (rd && paddr == 12'h014 |-> prdata inside {[1:32'h31]}) else $error("date");
  chk_month_range: assert property (rd && paddr == 12'h018 |-> prdata <= 32'h12) else $error("month");
  chk_year_pulse: assert property (year_carry_r |=> !year_carry_r) else $error("year carry held");
  cov_month_read: cover property (rd && paddr == 12'h018);
  cov_year_carry: cover property (year_carry_r);
  cov_slave_err: cover property (pslverr);
endmodule

/* bench/tb_rtc_calendar_counter_chain.sv */
/*
  Self-checking bench of the calendar chain, driving APB and the year input.
  Assumes TICK_CYCLES of 4, so one second takes 512 clock cycles.
*/
`timescale 1ns/100ps
module tb_rtc_calendar_counter_chain;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r;
  logic [7:0] year_bcd = 0;
  wire [31:0] prdata;
  wire pready, pslverr, year_carry_r;
  int errors = 0, n_tests = 0, ycnt = 0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (year_carry_r === 1'b1) ycnt++;
  rtcc_calendar #(.TICK_CYCLES(20'h4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .year_bcd(year_bcd), .year_carry_r(year_carry_r));
  task results;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] x);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1, a, d);
    chk(e, 0);
  endtask
  task rd(input [11:0] a, input [31:0] x);
    apb(0, a, 0);
    chk(r, x);
    chk(e, 0);
  endtask
  // Load {sec, min, hour, week, date, month, year}, run one second, stop and compare.
  task t_roll(input [55:0] c, input [47:0] x, input int yc);
    wr(12'h01c, 32'h0);
    for (int i = 0; i < 6; i++) wr(12'h004 + 4 * i, c[55 - 8 * i -: 8]);
    year_bcd <= c[7:0];
    ycnt = 0;
    wr(12'h01c, 32'h3);
    repeat (520) @(posedge pclk);
    wr(12'h01c, 32'h0);
    for (int i = 0; i < 6; i++) rd(12'h004 + 4 * i, x[47 - 8 * i -: 8]);
    chk(ycnt, yc);
  endtask
  task t_regs;
    wr(12'h01c, 32'h2);
    wr(12'h000, 32'hff);
    rd(12'h000, 32'h0);
    wr(12'h004, 32'hffffff59);
    rd(12'h004, 32'h59);
    wr(12'h00c, 32'hc0000023);
    rd(12'h00c, 32'h23);
    for (int i = 0; i < 7; i++) begin
      wr(12'h010, i);
      rd(12'h010, i);
    end
    apb(0, 12'h020, 0);
    chk(r, 32'h0);
    chk(e, 1);
    apb(1, 12'h005, 5);
    chk(e, 1);
  endtask
  task t_subsec;
    wr(12'h01c, 32'h3);
    repeat (40) @(posedge pclk);
    wr(12'h01c, 32'h0);
    apb(0, 12'h000, 0);
    chk(r >= 8 && r <= 12, 1);
    wr(12'h004, 32'h45);
    wr(12'h008, 32'h10);
    wr(12'h01c, 32'h4);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h11);
    rd(12'h000, 32'h0);
    rd(12'h01c, 32'h8);
    wr(12'h01c, 32'h0);
    rd(12'h01c, 32'h0);
  endtask
  // Leave a non-zero sub-second count, stop counting, reset, and expect it unchanged.
  task t_reset;
    logic [31:0] v;
    wr(12'h01c, 32'h3);
    repeat (20) @(posedge pclk);
    wr(12'h01c, 32'h0);
    apb(0, 12'h000, 0);
    v = r;
    chk(v >= 3 && v <= 7, 1);
    wr(12'h004, 32'h17);
    @(posedge pclk);
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, v);
    rd(12'h004, 32'h17);
    rd(12'h01c, 32'h1);
    wr(12'h01c, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_subsec();
    t_reset();
    t_roll(56'h59592306280223, 48'h000000000103, 0);
    t_roll(56'h59592301280224, 48'h000000022902, 0);
    t_roll(56'h59592301280200, 48'h000000022902, 0);
    t_roll(56'h59592305311299, 48'h000000060101, 1);
    t_roll(56'h59592303300423, 48'h000000040105, 0);
    t_roll(56'h59590902150723, 48'h000010021507, 0);
    results();
  end
  initial begin
    #200000;
    errors++;
    results();
  end
endmodule
bind rtcc_calendar rtcc_calendar_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .year_bcd(year_bcd), .year_carry_r(year_carry_r));
